// ### common/dmacfg_pkg.sv
// Functional notes
// - Writing 1 to bit 31 starts the channel with its loaded transfer setup.
// - A cleared enable stops the channel only at a transaction boundary.
// - Configuration word of an active channel reads as zero.
// - Done-stop and ready-pacing modes exist on channels 0 and 1 only.
// - Strobe held high keeps the engine in place; no new transfer starts.
// - Status-readability bit makes status registers show live values when active, except during the dummy fetch.
// - After a failure, continuation bit 1 restarts from the failed word.
// - Ready-pacing waits for the strobe before each next bus arbitration except the dummy fetch.
// - Done-mode strobe halts channel after current transaction and clears enable.
// - Strobe while awaiting mastership stops after the next transaction, then disables.
// - Word layout: 31 en, 30 cont, 29 status, 28 rdy, 27 done, 26:24 burst, 20 arb.
// - All configuration fields reset to zero.
// - Engine clears enable on completion; software restarts by setting it.
// - After the last word, registers read zero until the dummy fetch ends.
package dmacfg_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned PACE_CH = 2;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned FIFO_DEPTH = 8;

  // ----------------------------------------------------------------
  // Register map: channel in adr[5:4], register in adr[3:0]
  // ----------------------------------------------------------------
  localparam logic [3:0] OFF_CFG = 4'h0;
  localparam logic [3:0] OFF_CNT = 4'h4;
  localparam logic [3:0] OFF_STAT = 4'h8;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_EN = 31;
  localparam int unsigned BIT_CONT = 30;
  localparam int unsigned BIT_NFM = 29;
  localparam int unsigned BIT_RDY = 28;
  localparam int unsigned BIT_DONE = 27;
  localparam int unsigned BURST_MSB = 26;
  localparam int unsigned BURST_LSB = 24;
  localparam int unsigned BIT_ARB = 20;
  localparam int unsigned STAT_FAIL = 16;
  localparam int unsigned STAT_ACT = 17;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic en;
    logic cont;
    logic nfm;
    logic rdy;
    logic done;
    logic [2:0] burst;
    logic arb;
  } dmacfg_cfg_s;

  typedef struct packed {
    logic req;
    logic dummy;
    logic [1:0] chan;
    logic [DATA_W-1:0] data;
  } dmacfg_bus_s;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_PACE = 6'h02,
    ST_ARB = 6'h04,
    ST_XFER = 6'h08,
    ST_DARB = 6'h10,
    ST_DXFER = 6'h20
  } dmacfg_state_e;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam dmacfg_cfg_s CFG_RST = '0;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic SYNC_RST = 1'b1;

endpackage : dmacfg_pkg

// ### design/dmacfg_sync.sv
`timescale 1ns/1ps
module dmacfg_sync #(
  parameter int unsigned W = 2
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Raw and synchronised levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // Idle level of an active-low strobe, so reset reads as inactive
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_q <= {W{dmacfg_pkg::SYNC_RST}};
      sync_q <= {W{dmacfg_pkg::SYNC_RST}};
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;

endmodule : dmacfg_sync

// ### design/dmacfg_fifo.sv
`timescale 1ns/1ps
module dmacfg_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;

  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;

  assign in_ready_o = (cnt_q != DEPTH[AW:0]);
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rp_q];

  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_q[wp_q] <= in_data_i;
    end
  end

  // Depth is a power of two, so pointers wrap on overflow
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
      if (push && !pop) cnt_q <= cnt_q + 1'b1;
      else if (pop && !push) cnt_q <= cnt_q - 1'b1;
    end
  end

endmodule : dmacfg_fifo

// ### design/dmacfg_top.sv
`timescale 1ns/1ps
module dmacfg_top (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Source data stream
  input wire logic src_valid_i,
  output logic src_ready_o,
  input wire logic [31:0] src_data_i,
  // System bus transactions
  output dmacfg_pkg::dmacfg_bus_s bus_o,
  input wire logic bus_gnt_i,
  input wire logic bus_ack_i,
  input wire logic bus_err_i,
  // Pacing strobes of channels 0 and 1, active low
  input wire logic [1:0] pace_b_i
);

  localparam int unsigned NCH = dmacfg_pkg::NUM_CH;
  localparam int unsigned CW = dmacfg_pkg::CNT_W;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  dmacfg_pkg::dmacfg_cfg_s cfg_q [NCH];
  logic [CW-1:0] cnt_q [NCH];
  logic [CW-1:0] rem_q [NCH];
  logic [NCH-1:0] fail_q;
  dmacfg_pkg::dmacfg_state_e st_q;
  dmacfg_pkg::dmacfg_state_e st_d;
  logic [1:0] act_q;
  logic stop_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic dummy_q;
  logic [31:0] bdata_q;

  // ----------------------------------------------------------------
  // Pacing strobe synchroniser
  // ----------------------------------------------------------------
  logic [1:0] pace_s;

  dmacfg_sync #(
    .W(2)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .d_i(pace_b_i),
    .q_o(pace_s)
  );

  // Channels 2 and 3 have no strobe
  wire act_paced = (act_q < 2'd2);
  wire pace_act = act_paced & ~pace_s[act_q[0]];

  // ----------------------------------------------------------------
  // Data FIFO
  // ----------------------------------------------------------------
  logic fifo_v;
  logic [31:0] fifo_d;
  wire st_idle = (st_q == dmacfg_pkg::ST_IDLE);
  wire st_pace = (st_q == dmacfg_pkg::ST_PACE);
  wire st_arb = (st_q == dmacfg_pkg::ST_ARB);
  wire st_xfer = (st_q == dmacfg_pkg::ST_XFER);
  wire st_darb = (st_q == dmacfg_pkg::ST_DARB);
  wire st_dxfer = (st_q == dmacfg_pkg::ST_DXFER);
  wire ack_x = st_xfer & bus_ack_i & ~bus_err_i;
  wire err_x = st_xfer & bus_err_i;

  dmacfg_fifo #(
    .WIDTH(dmacfg_pkg::DATA_W),
    .DEPTH(dmacfg_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(src_valid_i),
    .in_ready_o(src_ready_o),
    .in_data_i(src_data_i),
    .out_valid_o(fifo_v),
    .out_ready_i(ack_x),
    .out_data_o(fifo_d)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire acc = wb_cyc_i & wb_stb_i & ~ack_q;
  wire in_map = (wb_adr_i[31:6] == 26'h0);
  wire [1:0] a_ch = wb_adr_i[5:4];
  wire [3:0] a_off = wb_adr_i[3:0];
  // Partial-word writes are acknowledged but not stored
  wire wr_acc = acc & wb_we_i & in_map & (wb_sel_i == 4'hf);
  wire rd_acc = acc & ~wb_we_i;
  wire busy = ~st_idle;
  wire flush = st_darb | st_dxfer;
  wire a_busy = busy & (act_q == a_ch);
  wire wr_cfg = wr_acc & (a_off == dmacfg_pkg::OFF_CFG);
  wire wr_cnt = wr_acc & (a_off == dmacfg_pkg::OFF_CNT);
  wire new_en = wb_dat_i[dmacfg_pkg::BIT_EN];
  wire new_cont = wb_dat_i[dmacfg_pkg::BIT_CONT];

  // Software disable of the running channel waits for a boundary
  wire sw_stop = wr_cfg & a_busy & ~new_en & ~flush;
  wire done_stop = busy & ~flush & cfg_q[act_q].done & pace_act;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [31:0] cfg_word;
  logic [31:0] stat_word;

  always_comb begin
    cfg_word = '0;
    cfg_word[dmacfg_pkg::BIT_EN] = cfg_q[a_ch].en;
    cfg_word[dmacfg_pkg::BIT_CONT] = cfg_q[a_ch].cont;
    cfg_word[dmacfg_pkg::BIT_NFM] = cfg_q[a_ch].nfm;
    cfg_word[dmacfg_pkg::BIT_RDY] = cfg_q[a_ch].rdy;
    cfg_word[dmacfg_pkg::BIT_DONE] = cfg_q[a_ch].done;
    cfg_word[dmacfg_pkg::BURST_MSB:dmacfg_pkg::BURST_LSB] = cfg_q[a_ch].burst;
    cfg_word[dmacfg_pkg::BIT_ARB] = cfg_q[a_ch].arb;
    stat_word = '0;
    stat_word[CW-1:0] = rem_q[a_ch];
    stat_word[dmacfg_pkg::STAT_FAIL] = fail_q[a_ch];
    stat_word[dmacfg_pkg::STAT_ACT] = a_busy;
  end

  // Live view only with the status-readability bit, never during flush
  wire hide = a_busy & (flush | ~cfg_q[a_ch].nfm);
  wire [31:0] rd_cfg = a_busy ? 32'h0 : cfg_word;
  wire [31:0] rd_cnt = hide ? 32'h0 : {16'h0, cnt_q[a_ch]};
  wire [31:0] rd_stat = hide ? 32'h0 : stat_word;
  wire [31:0] rd_data =
    !in_map ? dmacfg_pkg::RD_UNMAPPED :
    (a_off == dmacfg_pkg::OFF_CFG) ? rd_cfg :
    (a_off == dmacfg_pkg::OFF_CNT) ? rd_cnt :
    (a_off == dmacfg_pkg::OFF_STAT) ? rd_stat :
    dmacfg_pkg::RD_UNMAPPED;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end else begin
      ack_q <= acc;
      if (rd_acc) dat_q <= rd_data;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ----------------------------------------------------------------
  // Channel pick and engine
  // ----------------------------------------------------------------
  logic [NCH-1:0] en_vec;
  for (genvar g = 0; g < NCH; g++) begin : g_en
    assign en_vec[g] = cfg_q[g].en;
  end

  wire any_en = |en_vec;
  wire [1:0] pick = en_vec[0] ? 2'd0 : en_vec[1] ? 2'd1 :
                    en_vec[2] ? 2'd2 : 2'd3;
  wire last = (rem_q[act_q] == 16'h0001);
  wire stop_now = stop_q | sw_stop | done_stop;
  wire clr_en = (st_pace & stop_now) | err_x | (ack_x & stop_now) |
                (st_dxfer & (bus_ack_i | bus_err_i));

  always_comb begin
    st_d = st_q;
    case (st_q)
      dmacfg_pkg::ST_IDLE: begin
        if (any_en) begin
          if (rem_q[pick] == '0) st_d = dmacfg_pkg::ST_DARB;
          else if (cfg_q[pick].rdy) st_d = dmacfg_pkg::ST_PACE;
          else st_d = dmacfg_pkg::ST_ARB;
        end
      end
      dmacfg_pkg::ST_PACE: begin
        // Strobe high holds here with no request
        if (stop_now) st_d = dmacfg_pkg::ST_IDLE;
        else if (pace_act) st_d = dmacfg_pkg::ST_ARB;
      end
      dmacfg_pkg::ST_ARB: begin
        // A stop seen here still lets the next transaction run
        if (fifo_v && bus_gnt_i) st_d = dmacfg_pkg::ST_XFER;
      end
      dmacfg_pkg::ST_XFER: begin
        if (err_x) st_d = dmacfg_pkg::ST_IDLE;
        else if (ack_x) begin
          if (stop_now) st_d = dmacfg_pkg::ST_IDLE;
          else if (last) st_d = dmacfg_pkg::ST_DARB;
          else if (cfg_q[act_q].rdy) st_d = dmacfg_pkg::ST_PACE;
          else st_d = dmacfg_pkg::ST_ARB;
        end
      end
      dmacfg_pkg::ST_DARB: begin
        if (bus_gnt_i) st_d = dmacfg_pkg::ST_DXFER;
      end
      dmacfg_pkg::ST_DXFER: begin
        if (bus_ack_i || bus_err_i) st_d = dmacfg_pkg::ST_IDLE;
      end
      default: st_d = dmacfg_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= dmacfg_pkg::ST_IDLE;
      act_q <= 2'd0;
      stop_q <= 1'b0;
      dummy_q <= 1'b0;
      bdata_q <= '0;
    end else begin
      st_q <= st_d;
      if (st_idle) act_q <= pick;
      // Set wins; idle always clears, so no stop leaks to the next channel
      if (sw_stop || done_stop) stop_q <= 1'b1;
      else if (st_idle || st_d == dmacfg_pkg::ST_IDLE) stop_q <= 1'b0;
      if (st_arb && fifo_v && bus_gnt_i) bdata_q <= fifo_d;
      if (st_idle || st_pace) dummy_q <= 1'b0;
      if (st_d == dmacfg_pkg::ST_DARB) dummy_q <= 1'b1;
    end
  end

  assign bus_o.req = (st_arb & fifo_v) | st_darb;
  assign bus_o.dummy = dummy_q;
  assign bus_o.chan = act_q;
  assign bus_o.data = bdata_q;

  // ----------------------------------------------------------------
  // Per-channel registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < NCH; i++) begin
        cfg_q[i] <= dmacfg_pkg::CFG_RST;
        cnt_q[i] <= dmacfg_pkg::CNT_RST;
        rem_q[i] <= dmacfg_pkg::CNT_RST;
        fail_q[i] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (wr_cfg && a_ch == i[1:0] && !(busy && act_q == i[1:0])) begin
          cfg_q[i].en <= new_en;
          cfg_q[i].cont <= new_cont;
          cfg_q[i].nfm <= wb_dat_i[dmacfg_pkg::BIT_NFM];
          cfg_q[i].rdy <= (i < dmacfg_pkg::PACE_CH) &
                          wb_dat_i[dmacfg_pkg::BIT_RDY];
          cfg_q[i].done <= (i < dmacfg_pkg::PACE_CH) &
                           wb_dat_i[dmacfg_pkg::BIT_DONE];
          cfg_q[i].burst <=
            wb_dat_i[dmacfg_pkg::BURST_MSB:dmacfg_pkg::BURST_LSB];
          cfg_q[i].arb <= wb_dat_i[dmacfg_pkg::BIT_ARB];
          if (new_en && !cfg_q[i].en) begin
            // Continuation keeps the remaining count of the failed run
            if (!(fail_q[i] && new_cont)) rem_q[i] <= cnt_q[i];
            fail_q[i] <= 1'b0;
          end
        end
        if (wr_cnt && a_ch == i[1:0] && !(busy && act_q == i[1:0])) begin
          cnt_q[i] <= wb_dat_i[CW-1:0];
        end
        if (act_q == i[1:0] && busy) begin
          if (clr_en) cfg_q[i].en <= 1'b0;
          if (ack_x) rem_q[i] <= rem_q[i] - 1'b1;
          if (err_x) fail_q[i] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  a_cfg_read_zero: assert property (
    (rd_acc && in_map && a_off == dmacfg_pkg::OFF_CFG && a_busy)
    |=> (wb_ack_o && wb_dat_o == 32'h0))
    else $error("config word of active channel not read as zero");

  a_status_live: assert property (
    (rd_acc && in_map && a_off == dmacfg_pkg::OFF_STAT && a_busy &&
     !flush && cfg_q[a_ch].nfm)
    |=> wb_dat_o[dmacfg_pkg::STAT_ACT])
    else $error("live status not shown with readability bit");

  a_flush_hidden: assert property (
    (rd_acc && in_map && a_off != dmacfg_pkg::OFF_CFG && a_busy && flush)
    |=> wb_dat_o == 32'h0)
    else $error("register visible during dummy fetch");

  a_pace_hold: assert property (
    (st_pace && !pace_act && !stop_now) |=> (st_pace && !bus_o.req))
    else $error("engine left pacing wait with strobe high");

  a_pace_before_req: assert property (
    ($rose(bus_o.req) && !bus_o.dummy && cfg_q[act_q].rdy)
    |-> ($past(st_pace) && $past(pace_act)) || $past(st_arb))
    else $error("paced request without strobe wait");

  a_done_stop: assert property (
    (ack_x && stop_now) |=> (st_idle && !cfg_q[$past(act_q)].en))
    else $error("done stop did not halt and disable");

  a_stop_in_arb: assert property (
    (st_arb && done_stop) |=> (stop_q && !st_idle))
    else $error("stop in arbitration lost or premature");

  a_xfer_whole: assert property (
    (st_xfer && !bus_ack_i && !bus_err_i) |=> st_xfer)
    else $error("transaction cut short");

  a_no_pace_hi: assert property (
    !cfg_q[2].rdy && !cfg_q[2].done && !cfg_q[3].rdy && !cfg_q[3].done)
    else $error("pacing mode set on channel without strobe");

  a_cont_restart: assert property (
    (wr_cfg && a_ch == 2'd2 && !a_busy && new_en && new_cont &&
     fail_q[2] && !cfg_q[2].en)
    |=> (rem_q[2] == $past(rem_q[2]) && !fail_q[2]))
    else $error("continuation did not keep the failed position");

  a_flush_clear: assert property (
    (st_dxfer && bus_ack_i) |=> (st_idle && !cfg_q[$past(act_q)].en))
    else $error("enable not cleared after dummy fetch");

  c_paced_start: cover property (st_pace ##1 st_pace ##1 st_arb);
  c_done_halt: cover property (ack_x && done_stop);
  c_failure: cover property (err_x);
  c_fifo_full: cover property (src_valid_i && !src_ready_o);

endmodule : dmacfg_top

// ### testbench/dmacfg_pace_dev.sv
`timescale 1ns/1ps
// --------
// Slow peripheral driving the pacing strobes
// --------
module dmacfg_pace_dev (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Readiness request and response delay
  input wire logic [1:0] go_i,
  input wire logic [3:0] lag_i,
  // Strobes, active low, pulled up when idle
  output logic [1:0] pace_b_o
);
  logic [3:0] cnt_q [2];

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q[0] <= 4'h0;
      cnt_q[1] <= 4'h0;
      pace_b_o <= 2'b11;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (!go_i[c]) begin
          cnt_q[c] <= 4'h0;
          pace_b_o[c] <= 1'b1;
        end else if (cnt_q[c] >= lag_i) begin
          pace_b_o[c] <= 1'b0;
        end else begin
          cnt_q[c] <= cnt_q[c] + 4'h1;
        end
      end
    end
  end
endmodule : dmacfg_pace_dev

// ### testbench/dmacfg_top_bench.sv
`timescale 1ns/1ps
module dmacfg_top_bench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic wen = 1'b0;
  logic sv = 1'b0;
  logic gnt = 1'b0;
  logic bak = 1'b0;
  logic berr = 1'b0;
  logic [31:0] adr = 32'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] sdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] dat_o;
  logic [31:0] rnd = 32'h9b0f;
  logic [1:0] go = 2'b00;
  logic [1:0] pace_b;
  logic [1:0] exp_ch = 2'h0;
  logic [3:0] lag = 4'h2;
  logic ack;
  logic srdy;
  dmacfg_pkg::dmacfg_bus_s bus;
  logic [31:0] exp_q [$];
  int err_total = 0;
  int num_checks = 0;
  int words = 0;
  int dums = 0;
  int reqs = 0;
  int trn = 0;
  int slow = 0;
  int err_at = -1;
  int ph = 0;
  int wt = 0;

  always #50 clk = ~clk;

  dmacfg_top u_dmacfg_top (
    .core_clk_i(clk),
    .rst_b_i(rst_b),
    .wb_cyc_i(cyc),
    .wb_stb_i(stb),
    .wb_we_i(wen),
    .wb_adr_i(adr),
    .wb_sel_i(4'hf),
    .wb_dat_i(wdat),
    .wb_dat_o(dat_o),
    .wb_ack_o(ack),
    .src_valid_i(sv),
    .src_ready_o(srdy),
    .src_data_i(sdat),
    .bus_o(bus),
    .bus_gnt_i(gnt),
    .bus_ack_i(bak),
    .bus_err_i(berr),
    .pace_b_i(pace_b)
  );

  dmacfg_pace_dev u_dmacfg_pace_dev (
    .core_clk_i(clk),
    .rst_b_i(rst_b),
    .go_i(go),
    .lag_i(lag),
    .pace_b_o(pace_b)
  );

  // --------
  // Checks and report
  // --------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  task automatic fail(input string m);
    err_total++;
    $display("[FAIL] %0t %s", $time, m);
  endtask : fail

  task automatic hang();
    fail("wait ran out");
    give_verdict();
  endtask : hang

  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) fail($sformatf("read %h expected %h", g, e));
  endtask : chk_reg

  task automatic chk_num(input int g, input int e);
    num_checks++;
    if (g != e) fail($sformatf("count %0d expected %0d", g, e));
  endtask : chk_num

  // Failed word stays queued, it is resent later
  task automatic chk_bus(input logic bad);
    num_checks++;
    if (bus.dummy === 1'b1) begin
      dums++;
    end else if (exp_q.size() == 0 || bus.data !== exp_q[0]
                 || bus.chan !== exp_ch) begin
      fail($sformatf("word %h on channel %0d", bus.data, bus.chan));
    end else if (!bad) begin
      void'(exp_q.pop_front());
      words++;
    end
  endtask : chk_bus

  // --------
  // System bus responder, stalls by slow plus a random part
  // --------
  always @(posedge clk) begin
    rnd = lfsr(rnd);
    if (bus.req === 1'b1) reqs++;
    if (!rst_b) begin
      ph = 0;
      gnt <= 1'b0;
      bak <= 1'b0;
      berr <= 1'b0;
    end else begin
      case (ph)
        0: if (bus.req === 1'b1) begin
          wt = slow + int'(rnd[1:0]);
          ph = 1;
        end
        1: if (wt > 0) begin
          wt--;
        end else if (bus.req === 1'b1) begin
          gnt <= 1'b1;
          ph = 2;
        end else begin
          ph = 0;
        end
        2: begin
          gnt <= 1'b0;
          wt = slow + int'(rnd[2:0]);
          ph = 3;
        end
        3: if (wt > 0) begin
          wt--;
        end else begin
          bak <= (trn != err_at);
          berr <= (trn == err_at);
          chk_bus(trn == err_at);
          trn++;
          ph = 4;
        end
        default: begin
          bak <= 1'b0;
          berr <= 1'b0;
          ph = 0;
        end
      endcase
    end
  end

  // --------
  // Drivers
  // --------
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    wen <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20) hang();
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk_reg(rdat, e);
  endtask : rd

  // Stops at the first refusal
  task automatic push(input int k);
    for (int i = 0; i < k; i++) begin
      sv <= 1'b1;
      sdat <= rnd;
      @(posedge clk);
      if (srdy !== 1'b1) break;
      exp_q.push_back(sdat);
    end
    sv <= 1'b0;
  endtask : push

  task automatic until_t(input int t);
    int n;
    n = 0;
    while (trn < t && n < 500) begin
      @(posedge clk);
      n++;
    end
    if (n >= 500) hang();
    repeat (2) @(posedge clk);
  endtask : until_t

  task automatic do_reset(input int s, input logic [1:0] c);
    rst_b <= 1'b0;
    go <= 2'b00;
    repeat (3) @(posedge clk);
    exp_q.delete();
    words = 0;
    dums = 0;
    trn = 0;
    err_at = -1;
    slow = s;
    exp_ch = c;
    rst_b <= 1'b1;
    @(posedge clk);
  endtask : do_reset

  // --------
  // Scenarios
  // --------
  initial begin
    do_reset(3, 2'h3);
    for (int c = 0; c < 4; c++) begin
      rd({26'h0, c[1:0], 4'h0}, 32'h0);
      rd({26'h0, c[1:0], 4'h8}, 32'h0);
    end
    rd(32'h0000_0040, 32'h0);
    wb(1'b1, 32'h0, 32'h77ff_ffff);
    rd(32'h0, 32'h7710_0000);
    // Fill until refused, drain against a stalling bus
    push(9);
    chk_num(exp_q.size(), 8);
    wb(1'b1, 32'h34, 32'h8);
    wb(1'b1, 32'h30, 32'ha000_0000);
    rd(32'h30, 32'h0);
    wb(1'b0, 32'h38, 32'h0);
    chk_reg({31'h0, rdat[17]}, 32'h1);
    until_t(9);
    rd(32'h30, 32'h2000_0000);
    chk_num(dums, 1);
    // Ready pacing holds, then releases; channel 2 ignores it
    do_reset(0, 2'h0);
    push(2);
    wb(1'b1, 32'h04, 32'h2);
    wb(1'b1, 32'h00, 32'h9000_0000);
    reqs = 0;
    repeat (20) @(posedge clk);
    chk_num(reqs, 0);
    go <= 2'b01;
    until_t(3);
    chk_num(words, 2);
    exp_ch = 2'h2;
    go <= 2'b00;
    push(1);
    wb(1'b1, 32'h24, 32'h1);
    wb(1'b1, 32'h20, 32'h9000_0000);
    until_t(5);
    chk_num(words, 3);
    // Done strobe while waiting for mastership
    do_reset(6, 2'h1);
    push(4);
    wb(1'b1, 32'h14, 32'h4);
    wb(1'b1, 32'h10, 32'h8800_0000);
    until_t(1);
    go <= 2'b10;
    repeat (60) @(posedge clk);
    chk_num(words, 2);
    rd(32'h10, 32'h0800_0000);
    // Zero count goes straight to the dummy fetch, hidden despite bit 29
    wb(1'b1, 32'h30, 32'ha000_0000);
    rd(32'h38, 32'h0);
    // Failure, then resume at the failed word
    do_reset(1, 2'h2);
    push(3);
    err_at = 1;
    wb(1'b1, 32'h24, 32'h3);
    wb(1'b1, 32'h20, 32'hc000_0000);
    rd(32'h28, 32'h0);
    until_t(2);
    rd(32'h28, 32'h0001_0002);
    rd(32'h20, 32'h4000_0000);
    wb(1'b1, 32'h20, 32'hc000_0000);
    until_t(5);
    chk_num(words, 3);
    // Software stop lands between transactions
    do_reset(6, 2'h3);
    push(4);
    wb(1'b1, 32'h34, 32'h4);
    wb(1'b1, 32'h30, 32'h8000_0000);
    until_t(1);
    wb(1'b1, 32'h30, 32'h0);
    repeat (60) @(posedge clk);
    chk_num(words, 2);
    give_verdict();
  end
endmodule : dmacfg_top_bench
